// *** rtl/dwp_pkg.sv ***
// Purpose: Shared constants for the DDR write port with write masks
// Assumes: One system clock; each cycle stands for one input-clock edge
// Notes:   Organisation selects nibble or byte masking
//
// Overview of operation
// (RULE1) Capture data on true and complementary edges
// (RULE2) Write select low on true edge starts write
// (RULE3) Write select high ignores data, array unchanged
// (RULE4) Eight-bit organisation: two nibble masks, lanes 3..0/7..4
// (RULE5) Nibble mask sampled with its own data beat
// (RULE6) Byte masks select stored 9-bit bytes per beat
// (RULE7) Byte masks map to lanes 8..0 through 35..27
// (RULE8) Byte mask high on its edge discards byte
// (RULE9) Nibble and byte masks share identical beat timing
// (RULE10) Write address taken on complementary edge
// (RULE11) Every access starts on a true edge
// (RULE12) Write is two beats: true then complementary
package dwp_pkg;

    localparam int            DWP_DATA_W    = 36;
    localparam int            DWP_BYTES     = 4;
    localparam int            DWP_NIBBLES   = 2;
    localparam int            DWP_BYTE_W    = 9;
    localparam int            DWP_NIBBLE_W  = 4;
    localparam int            DWP_ORG_NIB   = 8;
    localparam int            DWP_ORG_DEF   = 36;
    localparam int            DWP_ADDR_W    = 4;
    localparam int            DWP_FIFO_D    = 8;
    localparam int            DWP_READY_GAP = 2;
    localparam logic          DWP_SEL_IDLE  = 1'b1;
    localparam logic [35:0]   DWP_DATA_RST  = 36'h0_0000_0000;
    localparam logic [3:0]    DWP_MASK_RST  = 4'hF;

    ////////////////////////////////////////////////////////////////////////
    // Bit enables from active-low masks for one beat
    function automatic logic [35:0] dwp_bit_en(
        input int         org,
        input logic [1:0] nib_n,
        input logic [3:0] byte_n
    );
        logic [35:0] en;
        en = 36'h0_0000_0000;
        for (int i = 0; i < DWP_DATA_W; i++)
        begin
            if (org == DWP_ORG_NIB)
            begin
                if (i < DWP_ORG_NIB)
                    en[i] = ~nib_n[i / DWP_NIBBLE_W]; // RULE4
            end
            else if (i < org)
            begin
                en[i] = ~byte_n[i / DWP_BYTE_W]; // RULE7
            end
        end
        return en;
    endfunction : dwp_bit_en

endpackage : dwp_pkg

// *** rtl/dwp_link_if.sv ***
// Purpose: Write-port wires between controller and memory device
// Assumes: Both ends on the same clock
// Notes:   k_true marks a cycle standing for the true clock edge
interface dwp_link_if
    import dwp_pkg::*;
#(
    parameter int AW = DWP_ADDR_W
);
    logic          k_true;
    logic          write_port_select_n;
    logic [AW-1:0] address;
    logic [35:0]   data;
    logic [1:0]    nibble_mask_n;
    logic [3:0]    byte_mask_n;
    logic          wr_ready;

    modport ctrl
    (
        output k_true,
        output write_port_select_n,
        output address,
        output data,
        output nibble_mask_n,
        output byte_mask_n,
        input  wr_ready
    );

    modport mem
    (
        input  k_true,
        input  write_port_select_n,
        input  address,
        input  data,
        input  nibble_mask_n,
        input  byte_mask_n,
        output wr_ready
    );
endinterface : dwp_link_if

// *** rtl/dwp_mem.sv ***
// Purpose: Memory device write port, FIFO and masked storage array
// Assumes: Controller honours wr_ready before starting a burst
// Notes:   Array is flip-flops; read port is for the user side
module dwp_fifo
    import dwp_pkg::*;
#(
    parameter int W = 8,
    parameter int D = DWP_FIFO_D
)
(
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data,
    output logic [$clog2(D+1)-1:0] level
);
    localparam int PW = $clog2(D);
    localparam int CW = $clog2(D+1);

    logic [W-1:0]  store [D];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic [PW-1:0] next_wr_ptr;
    logic [PW-1:0] next_rd_ptr;
    logic [CW-1:0] next_count;
    logic          push;
    logic          pop;

    always_comb
    begin
        in_ready    = (count < CW'(D));
        out_valid   = (count != '0);
        out_data    = store[rd_ptr];
        level       = count;
        push        = in_valid && in_ready;
        pop         = out_valid && out_ready;
        next_wr_ptr = push ? ((wr_ptr == PW'(D-1)) ? '0 : wr_ptr + 1'b1)
                           : wr_ptr;
        next_rd_ptr = pop ? ((rd_ptr == PW'(D-1)) ? '0 : rd_ptr + 1'b1)
                          : rd_ptr;
        next_count  = count + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else if (ce)
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // Storage has no reset; empty flag guards stale words
    always_ff @(posedge clock)
    begin
        if (ce && push)
            store[wr_ptr] <= in_data;
    end
endmodule : dwp_fifo

////////////////////////////////////////////////////////////////////////////
module dwp_mem
    import dwp_pkg::*;
#(
    parameter int ORG   = DWP_ORG_DEF,
    parameter int AW    = DWP_ADDR_W,
    parameter int FDEPTH = DWP_FIFO_D
)
(
    input  wire logic          clock,
    input  wire logic          rstn,
    input  wire logic          ce,
    dwp_link_if.mem            link,
    input  wire logic          array_ready,
    input  wire logic [AW-1:0] rd_addr,
    output logic [35:0]        rd_word0,
    output logic [35:0]        rd_word1,
    output logic               fifo_busy
);
    localparam int EW = AW + 4 * DWP_DATA_W;
    localparam int CW = $clog2(FDEPTH+1);

    logic          hold_valid;
    logic [35:0]   hold_data;
    logic [35:0]   hold_en;
    logic          next_hold_valid;
    logic [35:0]   next_hold_data;
    logic [35:0]   next_hold_en;
    logic [35:0]   beat_en;
    logic          push;
    logic          push_ready;
    logic [EW-1:0] push_entry;
    logic          pop_valid;
    logic [EW-1:0] pop_entry;
    logic [CW-1:0] level;
    logic          next_wr_ready;
    logic [35:0]   array0 [2**AW];
    logic [35:0]   array1 [2**AW];
    logic [AW-1:0] w_addr;

    ////////////////////////////////////////////////////////////////////////
    // Beat capture
    always_comb
    begin
        // Mask taken in the same cycle as its data beat
        beat_en = dwp_bit_en(ORG, link.nibble_mask_n,
                             link.byte_mask_n); // RULE5 RULE8 RULE9 RULE6
        // Select only counts on a true edge; high means no write
        next_hold_valid = link.k_true
                          && !link.write_port_select_n; // RULE2 RULE3 RULE11
        next_hold_data  = link.k_true ? link.data : hold_data; // RULE1
        next_hold_en    = link.k_true ? beat_en : hold_en;
        // Second beat and address on the complementary edge
        push       = hold_valid && !link.k_true; // RULE12 RULE10
        push_entry = {link.address, link.data, beat_en,
                      hold_data, hold_en}; // RULE1
        // Margin of one burst covers the registered ready lag
        next_wr_ready = (level <= CW'(FDEPTH - DWP_READY_GAP));
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            hold_valid    <= 1'b0;
            hold_data     <= DWP_DATA_RST;
            hold_en       <= DWP_DATA_RST;
            link.wr_ready <= 1'b0;
            fifo_busy     <= 1'b0;
        end
        else if (ce)
        begin
            hold_valid    <= next_hold_valid;
            hold_data     <= next_hold_data;
            hold_en       <= next_hold_en;
            link.wr_ready <= next_wr_ready;
            fifo_busy     <= (level != '0);
        end
    end

    dwp_fifo #(
        .W (EW),
        .D (FDEPTH)
    ) u_fifo (
        .clock     (clock),
        .rstn      (rstn),
        .ce        (ce),
        .in_valid  (push),
        .in_ready  (push_ready),
        .in_data   (push_entry),
        .out_valid (pop_valid),
        .out_ready (array_ready),
        .out_data  (pop_entry),
        .level     (level)
    );

    ////////////////////////////////////////////////////////////////////////
    // Masked array write; disabled lanes keep old contents
    assign w_addr = pop_entry[EW-1 -: AW];

    always_ff @(posedge clock)
    begin
        if (ce && pop_valid && array_ready)
        begin
            array0[w_addr] <= (array0[w_addr] & ~pop_entry[35:0])
                            | (pop_entry[71:36] & pop_entry[35:0]); // RULE4
            array1[w_addr] <= (array1[w_addr] & ~pop_entry[107:72])
                            | (pop_entry[143:108]
                               & pop_entry[107:72]); // RULE6
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_word0 <= DWP_DATA_RST;
            rd_word1 <= DWP_DATA_RST;
        end
        else if (ce)
        begin
            rd_word0 <= array0[rd_addr];
            rd_word1 <= array1[rd_addr];
        end
    end

    // Unused: push_ready is covered by wr_ready margin
    logic unused_ready;
    assign unused_ready = push_ready;
endmodule : dwp_mem

// *** rtl/dwp_ctrl.sv ***
// Purpose: Controller end driving two-beat masked write bursts
// Assumes: Device ready flag is registered and one burst deep
// Notes:   Requests are taken only before a true edge
module dwp_ctrl
    import dwp_pkg::*;
#(
    parameter int AW = DWP_ADDR_W
)
(
    input  wire logic          clock,
    input  wire logic          rstn,
    input  wire logic          ce,
    dwp_link_if.ctrl           link,
    input  wire logic          req_valid,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic [35:0]   req_data0,
    input  wire logic [35:0]   req_data1,
    input  wire logic [3:0]    req_mask0_n,
    input  wire logic [3:0]    req_mask1_n,
    output logic               req_ready
);
    typedef enum logic [2:0]
    {
        DWP_IDLE  = 3'b001,
        DWP_BEAT0 = 3'b010,
        DWP_BEAT1 = 3'b100
    } dwp_state_t;

    dwp_state_t    state;
    dwp_state_t    next_state;
    logic          next_k_true;
    logic          next_sel_n;
    logic [AW-1:0] next_addr;
    logic [35:0]   next_data;
    logic [3:0]    next_mask_n;
    logic          next_req_ready;
    logic [AW-1:0] b_addr;
    logic [35:0]   b_data1;
    logic [3:0]    b_mask1_n;
    logic [AW-1:0] next_b_addr;
    logic [35:0]   next_b_data1;
    logic [3:0]    next_b_mask1_n;
    logic          take;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_k_true    = !link.k_true;
        next_state     = state;
        next_sel_n     = DWP_SEL_IDLE;
        next_addr      = link.address;
        next_data      = link.data;
        next_mask_n    = DWP_MASK_RST;
        next_b_addr    = b_addr;
        next_b_data1   = b_data1;
        next_b_mask1_n = b_mask1_n;
        // Start only so beat 0 lands on a true edge
        take = (state == DWP_IDLE) && !link.k_true
               && req_valid && link.wr_ready; // RULE11
        next_req_ready = 1'b0;
        unique case (state)
            DWP_IDLE:
            begin
                if (take)
                begin
                    next_state     = DWP_BEAT0;
                    next_sel_n     = 1'b0; // RULE2
                    next_data      = req_data0; // RULE1
                    next_mask_n    = req_mask0_n; // RULE5 RULE8
                    next_b_addr    = req_addr;
                    next_b_data1   = req_data1;
                    next_b_mask1_n = req_mask1_n;
                    next_req_ready = 1'b1;
                end
            end
            DWP_BEAT0:
            begin
                next_state  = DWP_BEAT1;
                next_addr   = b_addr; // RULE10
                next_data   = b_data1; // RULE12
                next_mask_n = b_mask1_n; // RULE9
            end
            DWP_BEAT1:
            begin
                next_state = DWP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state                    <= DWP_IDLE;
            link.k_true              <= 1'b0;
            link.write_port_select_n <= DWP_SEL_IDLE;
            link.address             <= '0;
            link.data                <= DWP_DATA_RST;
            link.nibble_mask_n       <= DWP_MASK_RST[1:0];
            link.byte_mask_n         <= DWP_MASK_RST;
            req_ready                <= 1'b0;
            b_addr                   <= '0;
            b_data1                  <= DWP_DATA_RST;
            b_mask1_n                <= DWP_MASK_RST;
        end
        else if (ce)
        begin
            state                    <= next_state;
            link.k_true              <= next_k_true;
            link.write_port_select_n <= next_sel_n;
            link.address             <= next_addr;
            link.data                <= next_data;
            link.nibble_mask_n       <= next_mask_n[1:0]; // RULE4
            link.byte_mask_n         <= next_mask_n; // RULE7
            req_ready                <= next_req_ready;
            b_addr                   <= next_b_addr;
            b_data1                  <= next_b_data1;
            b_mask1_n                <= next_b_mask1_n;
        end
    end
endmodule : dwp_ctrl

// *** verif/dwp_link_chk.sv ***
// Purpose: Link checks between controller and memory ends
// Assumes: ce held high, so k_true toggles every cycle
// Notes:   Sees interface wires only
module dwp_link_chk
    import dwp_pkg::*;
#(
    parameter int AW = DWP_ADDR_W
)
(
    input wire logic          clock,
    input wire logic          rstn,
    input wire logic          k_true,
    input wire logic          write_port_select_n,
    input wire logic [AW-1:0] address,
    input wire logic [35:0]   data,
    input wire logic [1:0]    nibble_mask_n,
    input wire logic [3:0]    byte_mask_n,
    input wire logic          wr_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////
    sequence s_beat0;
        k_true && !write_port_select_n;
    endsequence
    sequence s_beat1;
        !k_true && write_port_select_n;
    endsequence

    // First edge after reset still sees the reset phase
    a_phase_flips: assert property
        ($past(rstn) |-> k_true != $past(k_true))
        else $error("phase did not alternate");
    a_sel_true_only: assert property
        (!write_port_select_n |-> k_true)
        else $error("select low off a true beat");
    a_beat_pair: assert property (s_beat0 |=> s_beat1)
        else $error("second beat missing");
    a_burst_gap: assert property
        (!write_port_select_n |=> write_port_select_n [*3])
        else $error("bursts too close");
    a_mask_idle: assert property
        ((k_true && write_port_select_n) |-> byte_mask_n == 4'hF)
        else $error("masks open while deselected");
    a_nib_mirror: assert property
        (nibble_mask_n == byte_mask_n[1:0])
        else $error("nibble masks differ from byte masks");
    a_start_room: assert property
        ($fell(write_port_select_n) |-> $past(wr_ready))
        else $error("burst started without room");
    a_ready_cause: assert property
        ($fell(wr_ready) |-> !(&{$past(write_port_select_n, 2),
                                 $past(write_port_select_n, 3),
                                 $past(write_port_select_n, 4)}))
        else $error("ready fell with no burst");
endmodule : dwp_link_chk

// *** verif/tb_top.sv ***
// Purpose: Random masked bursts end to end through the link
// Assumes: ORG 36 and ORG 8 ends in lockstep, ce high, readback by rd_addr
// Notes:   Shadow array holds the expected words
module tb_top
    import dwp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] MT [6] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hF, 4'h5};
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        ce = 1'b1;
    logic        array_ready = 1'b1;
    logic [3:0]  rd_addr = 4'h0;
    logic [35:0] rd_word0;
    logic [35:0] rd_word1;
    logic        fifo_busy;
    logic        req_ready;
    logic        req_valid = 1'b0;
    logic [3:0]  req_addr = 4'h0;
    logic [35:0] req_data0 = 36'h0;
    logic [35:0] req_data1 = 36'h0;
    logic [3:0]  req_mask0_n = 4'hF;
    logic [3:0]  req_mask1_n = 4'hF;
    logic [35:0] mem0 [16];
    logic [35:0] mem1 [16];
    logic [35:0] rd_nib0;
    logic [35:0] rd_nib1;
    logic        fifo_busy_nib;
    logic        req_ready_nib;
    logic [7:0]  mem8_0 [16];
    logic [7:0]  mem8_1 [16];
    logic [31:0] seed = 32'h0000_78AB;
    logic [31:0] r;
    int          num_errors = 0;
    int          checks = 0;
    int          taken;
    int          n;

    always #12.5 clock = ~clock;

    dwp_link_if link ();
    dwp_ctrl i_dwp_ctrl (.clock(clock), .rstn(rstn), .ce(ce), .link(link),
        .req_valid(req_valid), .req_addr(req_addr), .req_data0(req_data0),
        .req_data1(req_data1), .req_mask0_n(req_mask0_n),
        .req_mask1_n(req_mask1_n), .req_ready(req_ready));
    dwp_mem i_dwp_mem (.clock(clock), .rstn(rstn), .ce(ce), .link(link),
        .array_ready(array_ready), .rd_addr(rd_addr), .rd_word0(rd_word0),
        .rd_word1(rd_word1), .fifo_busy(fifo_busy));
    // Nibble organisation runs beside the byte one on the same stimulus
    dwp_link_if link_nib ();
    dwp_ctrl i_dwp_ctrl_nib (.clock(clock), .rstn(rstn), .ce(ce),
        .link(link_nib), .req_valid(req_valid), .req_addr(req_addr),
        .req_data0(req_data0), .req_data1(req_data1),
        .req_mask0_n(req_mask0_n), .req_mask1_n(req_mask1_n),
        .req_ready(req_ready_nib));
    dwp_mem #(.ORG(DWP_ORG_NIB)) i_dwp_mem_nib (.clock(clock), .rstn(rstn),
        .ce(ce), .link(link_nib), .array_ready(array_ready),
        .rd_addr(rd_addr), .rd_word0(rd_nib0), .rd_word1(rd_nib1),
        .fifo_busy(fifo_busy_nib));
    dwp_link_chk i_dwp_link_chk (.clock(clock), .rstn(rstn),
        .k_true(link.k_true), .write_port_select_n(link.write_port_select_n),
        .address(link.address), .data(link.data),
        .nibble_mask_n(link.nibble_mask_n), .byte_mask_n(link.byte_mask_n),
        .wr_ready(link.wr_ready));

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [35:0] byte_en(input logic [3:0] m);
        logic [35:0] e;
        for (int k = 0; k < 36; k++)
            e[k] = ~m[k / 9];
        return e;
    endfunction : byte_en

    function automatic logic [7:0] nib_en(input logic [3:0] m);
        return {{4{~m[1]}}, {4{~m[0]}}};
    endfunction : nib_en

    task automatic check(input string what, input logic [35:0] exp,
                         input logic [35:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask : check

    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    // arm: 0 array stalled, 1 running, 2 random per burst
    task automatic wr(input logic [3:0] a, input logic [3:0] m0,
                      input logic [3:0] m1, input int arm, input bit must);
        logic [35:0] d0;
        logic [35:0] d1;
        d0 = 36'(rnd()) ^ (36'(rnd()) << 4);
        d1 = 36'(rnd()) ^ (36'(rnd()) << 4);
        #2;
        array_ready = (arm == 2) ? (d0[7] | d0[8]) : arm[0];
        req_valid = 1'b1;
        req_addr = a;
        req_data0 = d0;
        req_data1 = d1;
        req_mask0_n = m0;
        req_mask1_n = m1;
        taken = 0;
        for (int i = 0; i < 24 && taken == 0; i++)
        begin
            @(posedge clock);
            taken = (req_ready === 1'b1);
            // A stalled array must not starve a random run
            if (i == 8 && arm == 2)
            begin
                #2;
                array_ready = 1'b1;
            end
        end
        // A late take still lands after withdrawal
        if (taken == 0)
        begin
            #2;
            req_valid = 1'b0;
            @(posedge clock);
            taken = (req_ready === 1'b1);
        end
        if (taken == 1)
        begin
            mem0[a] = (mem0[a] & ~byte_en(m0)) | (d0 & byte_en(m0));
            mem1[a] = (mem1[a] & ~byte_en(m1)) | (d1 & byte_en(m1));
            mem8_0[a] = (mem8_0[a] & ~nib_en(m0)) | (d0[7:0] & nib_en(m0));
            mem8_1[a] = (mem8_1[a] & ~nib_en(m1)) | (d1[7:0] & nib_en(m1));
            check("ready_nib", 36'h1, 36'(req_ready_nib));
        end
        else if (must)
        begin
            num_errors++;
            report_and_stop();
        end
    endtask : wr

    task automatic settle();
        #2;
        req_valid = 1'b0;
        array_ready = 1'b1;
        repeat (4) @(posedge clock);
        for (int i = 0; i < 64 && (fifo_busy | fifo_busy_nib) !== 1'b0; i++)
            @(posedge clock);
        if ((fifo_busy | fifo_busy_nib) !== 1'b0)
        begin
            num_errors++;
            report_and_stop();
        end
        #2;
        for (int a = 0; a < 16; a++)
        begin
            rd_addr = 4'(a);
            @(posedge clock);
            #2;
            check("word0", mem0[a], rd_word0);
            check("word1", mem1[a], rd_word1);
            check("nib0", 36'(mem8_0[a]), 36'(rd_nib0[7:0]));
            check("nib1", 36'(mem8_1[a]), 36'(rd_nib1[7:0]));
        end
        // Hand back on an edge so the next driver keeps its fixed delay
        @(posedge clock);
    endtask : settle

    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clock);
        check("sel_reset", 36'h1, 36'(link.write_port_select_n));
        #2;
        rstn = 1'b1;
        repeat (2) @(posedge clock);
        check("wr_ready", 36'h1, 36'(link.wr_ready));
        for (int a = 0; a < 16; a++)
            wr(4'(a), 4'h0, 4'h0, 2, 1);
        settle();
        for (int k = 0; k < 6; k++)
            wr(4'(k), MT[k], MT[5 - k], 1, 1);
        settle();
        for (int i = 0; i < 40; i++)
        begin
            r = rnd();
            wr(r[3:0], r[7:4], r[11:8], 2, 1);
        end
        settle();
        // Stalled array: room runs out near full depth
        n = 0;
        for (int i = 0; i < 12; i++)
        begin
            wr(4'(i), 4'h0, 4'h0, 0, 0);
            n += taken;
        end
        check("full", 36'h0, 36'(link.wr_ready));
        check("full_nib", 36'h0, 36'(link_nib.wr_ready));
        check("taken", 36'(DWP_FIFO_D - DWP_READY_GAP + 1), 36'(n));
        settle();
        report_and_stop();
    end
endmodule : tb_top
